// ==== common/ber_pkg.sv ====
package ber_pkg;
	// ***********************************
	// error detect register 1 bit positions
	// ***********************************
	localparam int EDR1_SRC_PCI = 3;
	localparam int EDR1_MEM_PAR = 2;
	localparam int EDR1_MEM_SEL = 5;
	localparam int EDR1_TGT_PERR = 6;
	localparam int EDR1_MST_SERR = 7;
	// ***********************************
	// error detect register 2 bit positions
	// ***********************************
	localparam int EDR2_L2_PAR = 4;
	localparam int EDR2_ADDR_INV = 7;
	// ***********************************
	// pci command and status bit positions
	// ***********************************
	localparam int CMD_PAR_RESP = 6;
	localparam int CMD_SERR_EN = 8;
	localparam int STS_PERR_RPT = 8;
	localparam int STS_SIG_TABT = 11;
	localparam int STS_RCV_TABT = 12;
	localparam int STS_RCV_MABT = 13;
	localparam int STS_SIG_SERR = 14;
	localparam int STS_DET_PERR = 15;
	// ***********************************
	// error enable bit positions
	// ***********************************
	localparam int EEN1_MABT = 1;
	localparam int EEN1_TABT = 7;
	localparam int EEN2_L2_PAR = 4;
	// ***********************************
	// reset values and timing
	// ***********************************
	localparam logic [7:0] EDR_RESET = 8'h00;
	localparam logic [15:0] STS_RESET = 16'h0000;
	localparam int DEVSEL_WAIT_CLKS = 5;
	localparam int SERR_DELAY_CLKS = 2;

	// error events from the memory and pci datapaths, one-cycle pulses
	typedef struct packed {
		logic mem_rd_par;     // dram read parity miscompare
		logic mem_sel;        // address beyond physical memory
		logic l2_rd_par;      // l2 read parity miscompare
		logic rd_by_pci;      // failing memory access came from a pci master
		logic mst_serr;       // target serr while we are master
		logic tgt_addr_par;   // address parity seen as target
		logic mst_data_par;   // read data parity seen as master
		logic mst_perr_in;    // target perr during our write
		logic tgt_wr_par;     // write data parity seen as target
		logic tgt_perr_in;    // master perr during our memory read
		logic rcv_tabt;       // our transaction was target-aborted
	} ber_evt_type;
endpackage

// ==== src/ber_error_unit.sv ====
`timescale 1ns/1ns
// Functional notes
// - read error source flag: pci set, cpu clear
// - address-invalid flag set for lone l2 errors
// - parity response off: log, finish normally
// - parity response on: target-abort pci reads
// - memory read parity sets detect bit two
// - out-of-bounds sets bit five, blocks row strobes
// - l2 parity enabled sets detect2 bit four
// - pci errors mark source pci, pci address
// - master sees serr: detect bit7, status15
// - target address parity: status15, serr, status14
// - address parity: target-abort, status11, machine check
// - foreign serr counted only when enabled
// - master data parity always sets status15
// - master parity: perr, status8, machine check
// - target write parity: perr, bit6, abort
// - master perr on read: abort, log address
// - parity response gates all target-abort cases
// - no devsel in five clocks: master-abort
// - master-abort machine check needs both enables
// - received target-abort: status12, gated machine check
// - nmi raises machine check, sets no flags
// - signalling follows cause by one cycle, serr by three
// - captured error locks until flags clear
// - enables gate latching and machine check
module ber_error_unit
	import ber_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire ber_evt_type evt,
	input wire logic [ADDR_W-1:0] err_addr_in,
	input wire logic pci_addr_start,
	input wire logic pci_master_cycle,
	input wire logic pci_devsel_b,
	input wire logic serr_in_b,
	input wire logic nmi,
	input wire logic mc_vector_fetch,
	input wire logic [15:0] pci_command,
	input wire logic [7:0] error_enable_reg1,
	input wire logic [7:0] error_enable_reg2,
	input wire logic machine_check_enable,
	input wire logic memory_parity_enable,
	input wire logic receive_syserr_enable,
	input wire logic [7:0] edr1_clear,
	input wire logic [7:0] edr2_clear,
	input wire logic [15:0] status_clear,
	output logic [7:0] error_detect_reg1,
	output logic [7:0] error_detect_reg2,
	output logic [15:0] pci_status,
	output logic [ADDR_W-1:0] err_addr,
	output logic target_abort,
	output logic master_abort,
	output logic serr_out_b,
	output logic perr_out_b,
	output logic ras_block,
	output logic machine_check_out
);
	// ***********************************
	// pin synchronisers
	// ***********************************
	logic [2:0] serr_s_r, serr_s_nxt;      // serr sampled, active high after inversion
	logic [2:0] nmi_s_r, nmi_s_nxt;        // nmi sampled
	logic serr_q_r, serr_q_nxt;            // settled serr level
	logic nmi_q_r, nmi_q_nxt;              // settled nmi level

	// stage one feeds stage two only; the settled level moves when two and three agree
	always_comb begin
		serr_s_nxt = {serr_s_r[1:0], ~serr_in_b};
		nmi_s_nxt = {nmi_s_r[1:0], nmi};
		serr_q_nxt = (serr_s_r[1] == serr_s_r[2]) ? serr_s_r[2] : serr_q_r;
		nmi_q_nxt = (nmi_s_r[1] == nmi_s_r[2]) ? nmi_s_r[2] : nmi_q_r;
	end

	// stages clear to the inactive level, so no false edge follows reset
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			serr_s_r <= 3'h0;
			nmi_s_r <= 3'h0;
			serr_q_r <= 1'b0;
			nmi_q_r <= 1'b0;
		end else if (clk_en) begin
			serr_s_r <= serr_s_nxt;
			nmi_s_r <= nmi_s_nxt;
			serr_q_r <= serr_q_nxt;
			nmi_q_r <= nmi_q_nxt;
		end
	end

	// foreign serr is a one-clock pulse on the bus; take its leading edge
	logic serr_prev_r, serr_prev_nxt;
	logic foreign_serr;
	assign serr_prev_nxt = serr_q_r;
	assign foreign_serr = serr_q_r & ~serr_prev_r & receive_syserr_enable;

	// ***********************************
	// devsel watchdog
	// ***********************************
	// one watch per master address phase; done lasts a single clock
	typedef enum logic [1:0] {
		BER_IDLE = 2'b00,
		BER_WAIT = 2'b01,
		BER_DONE = 2'b10
	} ber_ms_type;

	ber_ms_type ms_r, ms_nxt;
	logic [2:0] dcnt_r, dcnt_nxt;     // clocks since address phase start
	logic mabt_evt;                   // master-abort decision this cycle

	// special and configuration cycles are excluded by the caller via pci_master_cycle
	always_comb begin
		ms_nxt = ms_r;
		dcnt_nxt = dcnt_r;
		mabt_evt = 1'b0;
		unique case (ms_r)
			BER_IDLE: begin
				if (pci_addr_start && pci_master_cycle) begin
					ms_nxt = BER_WAIT;
					dcnt_nxt = 3'h1;
				end
			end
			BER_WAIT: begin
				// a claim on this clock ends the watch without an abort
				if (!pci_devsel_b) begin
					ms_nxt = BER_IDLE;
				end else if (dcnt_r == 3'(DEVSEL_WAIT_CLKS)) begin
					mabt_evt = 1'b1;
					ms_nxt = BER_DONE;
				end else begin
					dcnt_nxt = dcnt_r + 3'h1;
				end
			end
			BER_DONE: begin
				// rest one clock so the abort pulse is not re-armed at once
				ms_nxt = BER_IDLE;
			end
			default: begin
				// unused code falls back to idle
				ms_nxt = BER_IDLE;
			end
		endcase
	end

	// ***********************************
	// error capture
	// ***********************************
	logic par_resp;
	logic serr_en;
	logic locked;          // some detect flag is still set
	logic any_err;         // an enabled memory, pci or l2 error
	logic l2_chk;
	logic mem_err;
	logic pci_err;
	logic tabt_req;
	logic serr_req;
	logic perr_req;
	logic mc_req;
	logic [7:0] edr1_nxt;
	logic [7:0] edr2_nxt;
	logic [15:0] sts_nxt;
	logic [ADDR_W-1:0] addr_nxt;
	logic [1:0] serr_dly_r, serr_dly_nxt;  // address-parity serr delay line
	logic tabt_nxt, mabt_nxt, perr_nxt, mc_nxt, ras_nxt;

	// the lock spans both detect registers; software must clear them all
	assign par_resp = pci_command[CMD_PAR_RESP];
	assign serr_en = pci_command[CMD_SERR_EN];
	assign locked = (|error_detect_reg1) | (|error_detect_reg2);
	assign l2_chk = error_enable_reg2[EEN2_L2_PAR] & evt.l2_rd_par;
	assign mem_err = (memory_parity_enable & evt.mem_rd_par) | evt.mem_sel;
	assign pci_err = evt.mst_serr | evt.tgt_addr_par | evt.tgt_wr_par | evt.tgt_perr_in
		| foreign_serr;
	assign any_err = mem_err | pci_err | l2_chk;

	always_comb begin
		edr1_nxt = error_detect_reg1 & ~edr1_clear;
		edr2_nxt = error_detect_reg2 & ~edr2_clear;
		sts_nxt = pci_status & ~status_clear;
		addr_nxt = err_addr;
		// new flags land only while nothing is held; clear beats set otherwise
		if (!locked && (any_err || evt.mst_data_par || evt.mst_perr_in)) begin
			// a memory error's source follows whoever asked for the read
			if (mem_err && !pci_err) begin
				edr1_nxt[EDR1_SRC_PCI] = evt.rd_by_pci;
			end
			if (pci_err || evt.mst_data_par || evt.mst_perr_in) begin
				edr1_nxt[EDR1_SRC_PCI] = 1'b1;
			end
			if (memory_parity_enable && evt.mem_rd_par) begin
				edr1_nxt[EDR1_MEM_PAR] = 1'b1;
			end
			if (evt.mem_sel) begin
				edr1_nxt[EDR1_MEM_SEL] = 1'b1;
			end
			if (evt.tgt_wr_par) begin
				edr1_nxt[EDR1_TGT_PERR] = 1'b1;
			end
			if (evt.mst_serr) begin
				edr1_nxt[EDR1_MST_SERR] = 1'b1;
			end
			if (l2_chk) begin
				edr2_nxt[EDR2_L2_PAR] = 1'b1;
			end
			// l2 errors carry no usable address; mem_err and pci_err cases log the pci-side address
			edr2_nxt[EDR2_ADDR_INV] = l2_chk && !(mem_err || pci_err);
			if (mem_err || pci_err) begin
				addr_nxt = err_addr_in;
			end
		end
		// pci status bits are kept regardless of lock; bits 8, 11 and 14 need parity response on
		// every data parity fault except tgt_perr_in counts as detected, whatever the command bits
		if (evt.mst_serr || evt.tgt_addr_par || evt.mst_data_par || evt.mst_perr_in
			|| evt.tgt_wr_par) begin
			sts_nxt[STS_DET_PERR] = 1'b1;
		end
		if (par_resp && (evt.mst_data_par || evt.mst_perr_in)) begin
			sts_nxt[STS_PERR_RPT] = 1'b1;
		end
		if (serr_req) begin
			sts_nxt[STS_SIG_SERR] = 1'b1;
		end
		if (tabt_req) begin
			sts_nxt[STS_SIG_TABT] = 1'b1;
		end
		if (evt.rcv_tabt) begin
			sts_nxt[STS_RCV_TABT] = 1'b1;
		end
		if (mabt_evt) begin
			sts_nxt[STS_RCV_MABT] = 1'b1;
		end
	end

	// ***********************************
	// pci and processor signalling
	// ***********************************
	// target-abort covers every target case, all gated by parity response
	// the pulse comes even if the transfer ended; the bus logic drops it then
	assign tabt_req = par_resp & ((evt.rd_by_pci & mem_err) | evt.tgt_addr_par
		| foreign_serr | evt.tgt_wr_par | evt.tgt_perr_in);
	assign serr_req = serr_dly_r[1];
	assign perr_req = (par_resp & evt.mst_data_par) | evt.tgt_wr_par;
	// nmi keeps asking for as long as the pin stays up
	assign mc_req = machine_check_enable & (
		(evt.tgt_addr_par | evt.mst_data_par | evt.mst_perr_in | evt.tgt_wr_par
		| evt.tgt_perr_in | mem_err | l2_chk | foreign_serr | evt.mst_serr)
		| (mabt_evt & error_enable_reg1[EEN1_MABT])
		| (evt.rcv_tabt & error_enable_reg1[EEN1_TABT])
		| nmi_q_r);

	always_comb begin
		// serr_out_b follows the address phase by three clocks when both command bits allow
		serr_dly_nxt = {serr_dly_r[0], evt.tgt_addr_par & serr_en & par_resp};
		tabt_nxt = tabt_req;
		mabt_nxt = mabt_evt;
		perr_nxt = perr_req;
		ras_nxt = evt.mem_sel;
		// held until the processor fetches the machine-check vector
		mc_nxt = (machine_check_out & ~mc_vector_fetch) | mc_req;
	end

	// ***********************************
	// state and output registers
	// ***********************************
	// every signalling output is registered; all but serr_out_b trail their cause by a cycle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			// outputs idle inactive: low-active strobes high, pulses low
			ms_r <= BER_IDLE;
			dcnt_r <= 3'h0;
			serr_prev_r <= 1'b0;
			serr_dly_r <= 2'h0;
			error_detect_reg1 <= EDR_RESET;
			error_detect_reg2 <= EDR_RESET;
			pci_status <= STS_RESET;
			err_addr <= '0;
			target_abort <= 1'b0;
			master_abort <= 1'b0;
			serr_out_b <= 1'b1;
			perr_out_b <= 1'b1;
			ras_block <= 1'b0;
			machine_check_out <= 1'b0;
		end else if (clk_en) begin
			ms_r <= ms_nxt;
			dcnt_r <= dcnt_nxt;
			serr_prev_r <= serr_prev_nxt;
			serr_dly_r <= serr_dly_nxt;
			error_detect_reg1 <= edr1_nxt;
			error_detect_reg2 <= edr2_nxt;
			pci_status <= sts_nxt;
			err_addr <= addr_nxt;
			target_abort <= tabt_nxt;
			master_abort <= mabt_nxt;
			serr_out_b <= ~serr_req;
			perr_out_b <= ~perr_nxt;
			ras_block <= ras_nxt;
			machine_check_out <= mc_nxt;
		end
	end
endmodule

// ==== test/ber_far_side.sv ====
`timescale 1ns/1ns
// far side: pci target, nmi source and processor vector fetch
module ber_far_side (
	input wire logic mclk,
	input wire logic pci_addr_start,
	input wire logic [3:0] devsel_dly,
	input wire logic nmi_req,
	input wire logic flag_clr,
	input wire logic machine_check_out,
	output logic pci_devsel_b,
	output logic nmi,
	output logic mc_vector_fetch
);
	logic [3:0] cnt_r; // clocks since address phase
	logic [2:0] mc_r; // clocks machine check seen
	initial begin
		{cnt_r, mc_r, nmi, mc_vector_fetch} = '0;
		pci_devsel_b = 1'h1;
	end
	always @(posedge mclk) begin
		cnt_r <= pci_addr_start ? 4'h1 : cnt_r + {3'h0, cnt_r != 4'h0};
		// zero delay means nobody claims the cycle; line idles high on its pull-up
		pci_devsel_b <= !(devsel_dly != 4'h0 && cnt_r == devsel_dly);
		// nmi stays up until our own flag is cleared
		if (nmi_req) begin
			nmi <= 1'h1;
		end else if (flag_clr) begin
			nmi <= 1'h0;
		end
		// processor takes the exception a few clocks later
		mc_r <= machine_check_out ? mc_r + 3'h1 : 3'h0;
		mc_vector_fetch <= mc_r == 3'h3;
	end
endmodule

// ==== test/ber_error_unit_sva.sv ====
`timescale 1ns/1ns
module ber_error_unit_chk
	import ber_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire ber_evt_type evt,
	input wire logic pci_addr_start,
	input wire logic pci_master_cycle,
	input wire logic memory_parity_enable,
	input wire logic pci_devsel_b,
	input wire logic mc_vector_fetch,
	input wire logic [15:0] pci_command,
	input wire logic [7:0] error_enable_reg2,
	input wire logic [7:0] edr1_clear,
	input wire logic [7:0] error_detect_reg1,
	input wire logic [7:0] error_detect_reg2,
	input wire logic [15:0] pci_status,
	input wire logic [ADDR_W-1:0] err_addr,
	input wire logic target_abort,
	input wire logic master_abort,
	input wire logic serr_out_b,
	input wire logic perr_out_b,
	input wire logic ras_block,
	input wire logic machine_check_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic idle; // nothing latched, so a new error may land
	assign idle = clk_en && error_detect_reg1 == 8'h00 && error_detect_reg2 == 8'h00;
	a_mem_par_src: assert property (idle && memory_parity_enable && evt.mem_rd_par |=>
		error_detect_reg1[EDR1_MEM_PAR] && error_detect_reg1[EDR1_SRC_PCI] == $past(evt.rd_by_pci))
		else $error("memory parity flags wrong");
	a_sel_ras: assert property (clk_en && evt.mem_sel |=> ras_block)
		else $error("row strobes not blocked");
	a_l2_addr_inv: assert property (idle && error_enable_reg2[EEN2_L2_PAR] && evt.l2_rd_par
		|=> error_detect_reg2[EDR2_L2_PAR] && error_detect_reg2[EDR2_ADDR_INV])
		else $error("l2 parity flags wrong");
	a_wr_par_abort: assert property (clk_en && evt.tgt_wr_par && pci_command[CMD_PAR_RESP]
		|=> target_abort && !perr_out_b) else $error("write parity response missing");
	a_serr_delay: assert property (clk_en && evt.tgt_addr_par && pci_command[CMD_PAR_RESP]
		&& pci_command[CMD_SERR_EN] |-> ##3 (pci_status[STS_SIG_SERR] && !serr_out_b))
		else $error("system error timing wrong");
	a_lock_hold: assert property (error_detect_reg1 != 8'h00 && edr1_clear == 8'h00
		|=> $stable(err_addr) && $stable(error_detect_reg1)) else $error("locked error changed");
	a_mc_hold: assert property (machine_check_out && !mc_vector_fetch |=> machine_check_out)
		else $error("machine check dropped early");
	a_mabt_five: assert property (pci_addr_start && pci_master_cycle ##1 pci_devsel_b [*5]
		|=> master_abort && pci_status[STS_RCV_MABT]) else $error("master abort missing");
	c_tabt: cover property (target_abort);
	c_mabt: cover property (master_abort);
	c_mc_end: cover property ($fell(machine_check_out));
endmodule
bind ber_error_unit ber_error_unit_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top
	import ber_pkg::*;
;
	typedef struct packed {
		ber_evt_type e; logic [15:0] cmd; logic [7:0] d1; logic [7:0] d2; logic [15:0] sm;
		logic ta; logic pb;
	} ber_row_type;
	// *****
	// stimulus and observed pins
	// *****
	logic mclk = 1'h0, rst_b = 1'h0, clk_en = 1'h1, pci_addr_start = 1'h0, serr_in_b = 1'h1;
	logic pci_master_cycle = 1'h1, machine_check_enable = 1'h0, memory_parity_enable = 1'h1;
	logic receive_syserr_enable = 1'h1, nmi_req = 1'h0, flag_clr = 1'h0;
	ber_evt_type evt = '0;
	logic [31:0] err_addr_in = '0, err_addr;
	logic [15:0] pci_command = '0, status_clear = '0, pci_status;
	logic [7:0] error_enable_reg1 = 8'h82, error_enable_reg2 = 8'h10, edr1_clear = '0;
	logic [7:0] edr2_clear = '0, error_detect_reg1, error_detect_reg2;
	logic [3:0] devsel_dly = '0;
	logic target_abort, master_abort, serr_out_b, perr_out_b, ras_block, machine_check_out;
	logic pci_devsel_b, nmi, mc_vector_fetch;
	int err_count = 0, total_checks = 0;
	ber_row_type rows [9] = '{
		'{11'h400, 16'h0000, 8'h04, 8'h00, 16'h0000, 1'h0, 1'h1},
		'{11'h480, 16'h0040, 8'h0c, 8'h00, 16'h0000, 1'h1, 1'h1},
		'{11'h200, 16'h0000, 8'h20, 8'h00, 16'h0000, 1'h0, 1'h1},
		'{11'h100, 16'h0000, 8'h00, 8'h90, 16'h0000, 1'h0, 1'h1},
		'{11'h040, 16'h0000, 8'h88, 8'h00, 16'h8000, 1'h0, 1'h1},
		'{11'h010, 16'h0040, 8'h08, 8'h00, 16'h8100, 1'h0, 1'h0},
		'{11'h008, 16'h0040, 8'h08, 8'h00, 16'h8100, 1'h0, 1'h1},
		'{11'h004, 16'h0040, 8'h48, 8'h00, 16'h8000, 1'h1, 1'h0},
		'{11'h002, 16'h0040, 8'h08, 8'h00, 16'h0000, 1'h1, 1'h1}};
	ber_error_unit u_dut (.*);
	ber_far_side u_far (.*);
	initial forever #25 mclk = ~mclk;
	task automatic send(ber_evt_type e, logic [31:0] a);
		@(posedge mclk);
		evt <= e;
		err_addr_in <= a;
		@(posedge mclk);
		evt <= '0;
		#1;
	endtask
	// write-one-to-clear everything so the next error can latch
	task automatic clear_all();
		@(posedge mclk);
		{edr1_clear, edr2_clear, status_clear} <= '1;
		@(posedge mclk);
		{edr1_clear, edr2_clear, status_clear} <= '0;
		#1;
	endtask
	// bounded wait for the processor to take the exception
	task automatic wait_mc_end();
		for (int n = 0; n < 24 && machine_check_out !== 1'h0; n++) @(posedge mclk);
		#1;
		`CHK(machine_check_out, 1'h0)
		clear_all();
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		complete_run();
	end
	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'h1;
		#1;
		`CHK({error_detect_reg1, pci_status, serr_out_b}, {EDR_RESET, STS_RESET, 1'h1})
		foreach (rows[i]) begin
			pci_command <= rows[i].cmd;
			send(rows[i].e, 32'h0000_1000);
			`CHK({error_detect_reg1, error_detect_reg2}, {rows[i].d1, rows[i].d2})
			`CHK({pci_status & rows[i].sm, target_abort}, {rows[i].sm, rows[i].ta})
			`CHK(perr_out_b, rows[i].pb)
			`CHK(ras_block, rows[i].e.mem_sel)
			clear_all();
		end
		// second error must not disturb the first one's record
		send(11'h200, 32'h0000_a000);
		send(11'h480, 32'h0000_b000);
		`CHK({err_addr, error_detect_reg1}, {32'h0000_a000, 8'h20})
		clear_all();
		`CHK(error_detect_reg1, 8'h00)
		machine_check_enable <= 1'h1;
		pci_command <= 16'h0140;
		send(11'h020, 32'h0000_c000);
		`CHK({target_abort, pci_status & 16'h8800, machine_check_out}, {1'h1, 16'h8800, 1'h1})
		repeat (2) @(posedge mclk);
		#1;
		`CHK({serr_out_b, pci_status[STS_SIG_SERR]}, 2'h1)
		wait_mc_end();
		for (int k = 0; k < 2; k++) begin
			error_enable_reg1 <= k ? 8'h82 : 8'h00;
			send(11'h001, 32'h0000_d000);
			`CHK({pci_status[STS_RCV_TABT], machine_check_out}, {1'h1, k[0]})
			wait_mc_end();
			devsel_dly <= k ? 4'h0 : 4'h2;
			@(posedge mclk);
			pci_addr_start <= 1'h1;
			@(posedge mclk);
			pci_addr_start <= 1'h0;
			repeat (5) @(posedge mclk);
			#1;
			`CHK({master_abort, pci_status[STS_RCV_MABT]}, {2{k[0]}})
			`CHK(machine_check_out, k[0])
			wait_mc_end();
		end
		@(posedge mclk);
		nmi_req <= 1'h1;
		@(posedge mclk);
		nmi_req <= 1'h0;
		repeat (6) @(posedge mclk);
		#1;
		`CHK({machine_check_out, error_detect_reg1, error_detect_reg2}, {1'h1, 16'h0000})
		flag_clr <= 1'h1;
		@(posedge mclk);
		flag_clr <= 1'h0;
		wait_mc_end();
		// special and configuration cycles never arm the devsel watch
		pci_master_cycle <= 1'h0;
		@(posedge mclk);
		pci_addr_start <= 1'h1;
		@(posedge mclk);
		pci_addr_start <= 1'h0;
		repeat (5) @(posedge mclk);
		#1;
		`CHK(master_abort, 1'h0)
		pci_master_cycle <= 1'h1;
		// foreign serr held two clocks so the pin filter lets it through
		for (int k = 0; k < 2; k++) begin
			receive_syserr_enable <= k[0];
			@(posedge mclk);
			serr_in_b <= 1'h0;
			repeat (2) @(posedge mclk);
			serr_in_b <= 1'h1;
			repeat (3) @(posedge mclk);
			#1;
			`CHK({error_detect_reg1, target_abort}, {k ? 8'h08 : 8'h00, k[0]})
			wait_mc_end();
		end
		// memory parity checking switched off: a miscompare is not logged
		memory_parity_enable <= 1'h0;
		send(11'h400, 32'h0000_9000);
		`CHK(error_detect_reg1, 8'h00)
		memory_parity_enable <= 1'h1;
		// frozen clock enable: the access is simply missed
		clk_en <= 1'h0;
		send(11'h200, 32'h0000_e000);
		`CHK({error_detect_reg1, ras_block}, 9'h000)
		clk_en <= 1'h1;
		// reset in mid-run wipes a held record
		send(11'h200, 32'h0000_f000);
		`CHK(error_detect_reg1, 8'h20)
		rst_b <= 1'h0;
		@(posedge mclk);
		#1;
		`CHK({error_detect_reg1, err_addr, serr_out_b}, {EDR_RESET, 32'h0000_0000, 1'h1})
		rst_b <= 1'h1;
		@(posedge mclk);
		#1;
		`CHK({error_detect_reg1, pci_status}, {EDR_RESET, STS_RESET})
		complete_run();
	end
endmodule
